// file: dac_pwr_pkg.sv
/*
  Constants for the converter power-up sequencer: register offsets,
  field positions, reset values and wake-up timing.
  Assumes a 40 MHz core clock.
*/
package dac_pwr_pkg;
  // ==========================================================
  // Register map
  localparam logic [9:0] REG_DAC_POWER_DOWN_CTRL    = 10'h011;
  localparam logic [9:0] REG_SYNC_OUTPUT_SWING_CTRL = 10'h2A5;
  localparam int         ADDR_W                     = 10;
  localparam int         DATA_W                     = 8;
  // ==========================================================
  // Reset values and power-down codes
  localparam logic [7:0] PD_RESET_VAL    = 8'h7C;
  localparam logic [7:0] SWING_RESET_VAL = 8'h00;
  localparam logic [7:0] PD_CODE_PAIR_A  = 8'h60;
  localparam logic [7:0] PD_CODE_PAIR_B  = 8'h18;
  localparam logic [7:0] PD_CODE_ALL     = 8'h7C;
  localparam logic [7:0] PD_CODE_NONE    = 8'h00;
  localparam int         SWING_HIGH_BIT  = 0;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int WAKE_TIME_US     = 60;
  localparam int WAKE_CYCLES      = (WAKE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int LANE_DIV         = 40;
  localparam int LANE_DIV_HALF    = LANE_DIV / 2;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAKE  = 2'b01
  } seq_state_e;
endpackage

// file: lane_clk_div.sv
/*
  Divides the lane-rate clock by forty to form the processing clock.
  Assumes the lane clock input is a synchronous strobe per unit interval.
*/
`timescale 1ns/1ps
`default_nettype none
module lane_clk_div (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  // Lane unit-interval strobe
  input  wire logic lane_ui_in,
  // Processing clock
  output var  logic processing_clock_out
);
  import dac_pwr_pkg::*;
  logic [5:0] ui_cnt_r;
  // ==========================================================
  // Count unit intervals; toggle every twenty for a 50% duty
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ui_cnt_r             <= 6'h00;
      processing_clock_out <= 1'b0;
    end else if (lane_ui_in) begin
      if (ui_cnt_r == 6'(LANE_DIV_HALF - 1)) begin
        ui_cnt_r             <= 6'h00;
        processing_clock_out <= ~processing_clock_out;
      end else begin
        ui_cnt_r <= ui_cnt_r + 6'h01;
      end
    end
  end
endmodule // lane_clk_div
`default_nettype wire

// file: dac_path_powerup_sync_cfg.sv
/*
  Power-up sequencer, sync swing select and processing clock for the
  converter digital path. Registers written on a plain synchronous port.
  Assumes the host drives one-cycle write strobes synchronous to core_clk_in.

  What the block holds
    - Power-down control register. Each pair of converters has two
      power-down bits; either bit set keeps that pair off.
    - Sync output swing register. Only bit 0 is used; it picks the
      normal or the high differential swing of the link sync output.
    - A wake sequencer that counts a fixed interval after the
      power-down register is cleared, then reports ready only a pair whose
      old code was exactly its pair code or the all-off code.
    - A divider that turns the lane unit-interval strobe into the
      processing clock.

  Behaviour a user must know
    - A wake starts only when all-zero is written over a nonzero code.
      Rewriting zero while already zero does nothing at all.
    - Any nonzero code written during a wake aborts it. The pending
      flag drops at once and no pair is reported ready, so software
      never sees a pair come up that it has just turned off again.
    - A pair that is set off by a write loses its ready flag on the
      next edge, whether or not a wake is running.
    - The wake interval is a fixed count of core clocks; it assumes
      the core clock runs at its nominal rate. A slower clock only
      makes the interval longer, which errs on the safe side.
    - Read data is registered and stands until the next read strobe.
      Unmapped reads return zero; unmapped writes are dropped.

  What it assumes of its surroundings
    - All inputs are synchronous to core_clk_in.
    - The lane strobe is at most one pulse per core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_path_powerup_sync_cfg (
  // Clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            reset_n_in,
  // Register port
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  input  wire logic [dac_pwr_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [dac_pwr_pkg::DATA_W-1:0]  reg_wdata_in,
  output var  logic [dac_pwr_pkg::DATA_W-1:0]  reg_rdata_out,
  // Lane timing
  input  wire logic                            lane_ui_in,
  output var  logic                            processing_clock_out,
  // Channel power and sync swing
  output var  logic                            pair_a_ready_out,
  output var  logic                            pair_b_ready_out,
  output var  logic                            powerup_pending_out,
  output var  logic                            sync_high_swing_out
);
  import dac_pwr_pkg::*;

  logic [7:0]  pd_ctrl_r;
  logic [7:0]  swing_ctrl_r;
  logic [21:0] wake_cnt_r;
  logic        wake_a_r;
  logic        wake_b_r;
  seq_state_e  state_r;
  logic        pd_wr;
  logic        swing_wr;
  logic        wake_req;
  logic        pd_cancel;
  logic        wake_done;
  logic        pair_a_off_req;
  logic        pair_b_off_req;

  // ==========================================================
  // Write decode
  assign pd_wr    = reg_wr_in && (reg_addr_in == REG_DAC_POWER_DOWN_CTRL);
  assign swing_wr = reg_wr_in && (reg_addr_in == REG_SYNC_OUTPUT_SWING_CTRL);

  // Wake request: all channels on, coming from a powered-down code
  assign wake_req  = pd_wr && (reg_wdata_in == PD_CODE_NONE) && (pd_ctrl_r != PD_CODE_NONE);
  // Any nonzero code aborts a running wake; rewriting zero is a no-op
  assign pd_cancel = pd_wr && (reg_wdata_in != PD_CODE_NONE);
  // Last counted cycle of the wake interval
  assign wake_done = (state_r == ST_WAKE) && (wake_cnt_r == 22'(WAKE_CYCLES - 1));
  // Either power-down bit of a pair takes that pair down
  assign pair_a_off_req = pd_wr && (reg_wdata_in[6] || reg_wdata_in[5]);
  assign pair_b_off_req = pd_wr && (reg_wdata_in[4] || reg_wdata_in[3]);

  // ==========================================================
  // Processing clock divider
  lane_clk_div u_div (
    .core_clk_in          (core_clk_in),
    .reset_n_in           (reset_n_in),
    .lane_ui_in           (lane_ui_in),
    .processing_clock_out (processing_clock_out)
  );

  // ==========================================================
  // Register storage
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_ctrl_r    <= PD_RESET_VAL;
      swing_ctrl_r <= SWING_RESET_VAL;
    end else begin
      if (pd_wr) begin
        pd_ctrl_r <= reg_wdata_in;
      end
      if (swing_wr) begin
        swing_ctrl_r <= reg_wdata_in;
      end
    end
  end

  // Read data; unmapped addresses read as zero
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_DAC_POWER_DOWN_CTRL:    reg_rdata_out <= pd_ctrl_r;
        REG_SYNC_OUTPUT_SWING_CTRL: reg_rdata_out <= swing_ctrl_r;
        default:                    reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Sync output swing: bit clear is normal, set is high
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_high_swing_out <= 1'b0;
    end else begin
      sync_high_swing_out <= swing_ctrl_r[SWING_HIGH_BIT];
    end
  end

  // ==========================================================
  // Wake sequencer; a fresh request restarts the interval so the
  // pending flag always covers the newest request. A nonzero code
  // aborts the wake, so a pair turned back off never comes up.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r    <= ST_IDLE;
      wake_cnt_r <= 22'h000000;
      wake_a_r   <= 1'b0;
      wake_b_r   <= 1'b0;
    end else if (wake_req) begin
      state_r    <= ST_WAKE;
      wake_cnt_r <= 22'h000000;
      // Only a pair whose old code was exactly its pair code or PD_CODE_ALL gets woken
      wake_a_r   <= (pd_ctrl_r == PD_CODE_PAIR_A) || (pd_ctrl_r == PD_CODE_ALL);
      wake_b_r   <= (pd_ctrl_r == PD_CODE_PAIR_B) || (pd_ctrl_r == PD_CODE_ALL);
    end else if (pd_cancel) begin
      // Abort: nothing of the old request may survive
      state_r    <= ST_IDLE;
      wake_cnt_r <= 22'h000000;
      wake_a_r   <= 1'b0;
      wake_b_r   <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          wake_cnt_r <= 22'h000000;
        end
        ST_WAKE: begin
          if (wake_done) begin
            state_r <= ST_IDLE;
          end else begin
            wake_cnt_r <= wake_cnt_r + 22'h000001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pair A ready: drops on a power-down write, rises only when
  // its own wake interval ends without being aborted
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pair_a_ready_out <= 1'b0;
    end else if (pair_a_off_req) begin
      pair_a_ready_out <= 1'b0;
    end else if (wake_done && wake_a_r && !pd_cancel) begin
      pair_a_ready_out <= 1'b1;
    end
  end

  // Pair B ready: same scheme as pair A
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pair_b_ready_out <= 1'b0;
    end else if (pair_b_off_req) begin
      pair_b_ready_out <= 1'b0;
    end else if (wake_done && wake_b_r && !pd_cancel) begin
      pair_b_ready_out <= 1'b1;
    end
  end

  // Pending flag; a zero rewrite leaves it alone so a running
  // interval is never cut short by a harmless write
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      powerup_pending_out <= 1'b0;
    end else if (wake_req) begin
      powerup_pending_out <= 1'b1;
    end else if (pd_cancel || wake_done) begin
      powerup_pending_out <= 1'b0;
    end
  end
endmodule // dac_path_powerup_sync_cfg
`default_nettype wire

// file: dac_pwr_monitor.sv
/* Port checker for the power-up sequencer.
   Assumes it is bound onto the top module by the bench. */
`timescale 1ns/1ps
`default_nettype none
module dac_pwr_monitor import dac_pwr_pkg::*; (
  // All top ports, observed only
  input wire logic       core_clk_in, reset_n_in, reg_wr_in, reg_rd_in, lane_ui_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in, reg_rdata_out,
  input wire logic       processing_clock_out, pair_a_ready_out, pair_b_ready_out,
  input wire logic       powerup_pending_out, sync_high_swing_out
);
  // ==========================================
  // Helper counters
  logic [11:0] wake_cnt;
  logic [4:0]  ui_cnt;
  wire pd_wr = reg_wr_in && reg_addr_in == REG_DAC_POWER_DOWN_CTRL;
  // Restart on any power-down write, including the zero rewrites the sequencer ignores
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) wake_cnt <= 12'h000;
    else wake_cnt <= (!powerup_pending_out || pd_wr) ? 12'h000 : wake_cnt + 12'h001;
  end
  // Strobes seen since the last divider toggle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) ui_cnt <= 5'h00;
    else ui_cnt <= $changed(processing_clock_out) ? 5'h00 : ui_cnt + 5'(lane_ui_in);
  end
  // ==========================================
  // Properties
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_wake_req;
    pd_wr && reg_wdata_in == PD_CODE_NONE && !powerup_pending_out && !pair_a_ready_out && !pair_b_ready_out;
  endsequence
  a_pend_start: assert property (s_wake_req |=> powerup_pending_out) else $error("pending not raised");
  a_pend_bound: assert property (wake_cnt <= 12'h960) else $error("pending too long");
  a_rdy_a_end: assert property ($rose(pair_a_ready_out) |-> $fell(powerup_pending_out)) else $error("pair a early");
  a_rdy_b_end: assert property ($rose(pair_b_ready_out) |-> $fell(powerup_pending_out)) else $error("pair b early");
  a_drop_a: assert property (pd_wr && |reg_wdata_in[6:5] |=> !pair_a_ready_out) else $error("pair a kept");
  a_drop_b: assert property (pd_wr && |reg_wdata_in[4:3] |=> !pair_b_ready_out) else $error("pair b kept");
  a_swing_sel: assert property (reg_wr_in && reg_addr_in == REG_SYNC_OUTPUT_SWING_CTRL |-> ##2
    sync_high_swing_out == $past(reg_wdata_in[0], 2)) else $error("swing wrong");
  a_lane_div: assert property (ui_cnt <= 5'h14) else $error("divider slow");
  a_pclk_edge: assert property ($changed(processing_clock_out) |-> ui_cnt == 5'h14) else $error("divider fast");
endmodule // dac_pwr_monitor
`default_nettype wire

// file: lane_ui_partner.sv
/* Far-side lane model: one unit-interval strobe every third core cycle.
   Assumes the bench shares the core clock. */
`timescale 1ns/1ps
`default_nettype none
module lane_ui_partner (
  input  wire logic core_clk_in,
  output var  logic lane_ui_in
);
  logic [1:0] phase_r = 2'h0;
  // Sparse strobes so the divider cannot count clocks instead
  always @(negedge core_clk_in) begin
    phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    lane_ui_in <= (phase_r == 2'h0);
  end
  initial lane_ui_in = 1'b0;
endmodule // lane_ui_partner
`default_nettype wire

// file: dac_path_powerup_sync_cfg_tb_top.sv
/* Bench for the power-up sequencer: register calls with expected values.
   Assumes the design package and the lane partner model. */
`timescale 1ns/1ps
`default_nettype none
module dac_path_powerup_sync_cfg_tb_top;
  import dac_pwr_pkg::*;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, lane_ui_in;
  logic [9:0] reg_addr_in = 10'h000;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic processing_clock_out, pair_a_ready_out, pair_b_ready_out, powerup_pending_out, sync_high_swing_out;
  int errors = 0, compares = 0, n, ui_seen = 0, tog_seen = 0;
  logic [7:0] codes [3] = '{8'h60, 8'h18, 8'h7C};
  always #12.5 core_clk_in = ~core_clk_in;
  dac_path_powerup_sync_cfg dut (.*);
  lane_ui_partner lane (.*);
  // ==========================================
  // Reference lane and divider counts
  always @(posedge core_clk_in) if (reset_n_in) ui_seen += int'(lane_ui_in);
  always @(processing_clock_out) if (reset_n_in) tog_seen++;
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(negedge core_clk_in) {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
    @(negedge core_clk_in) reg_wr_in = 1'b0;
  endtask
  // Data is sampled a cycle after the strobe drops
  task automatic rd(logic [9:0] a, logic [7:0] exp);
    @(negedge core_clk_in) {reg_rd_in, reg_addr_in} = {1'b1, a};
    @(negedge core_clk_in) reg_rd_in = 1'b0;
    @(negedge core_clk_in) chk("rdata", exp, reg_rdata_out);
  endtask
  task automatic summarize();
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (20) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    rd(REG_DAC_POWER_DOWN_CTRL, PD_RESET_VAL);
    rd(10'h3FF, 8'h00);
    foreach (codes[i]) begin
      wr(REG_DAC_POWER_DOWN_CTRL, PD_CODE_ALL);
      wr(REG_DAC_POWER_DOWN_CTRL, codes[i]);
      wr(REG_DAC_POWER_DOWN_CTRL, PD_CODE_NONE);
      @(negedge core_clk_in) chk("pending", 8'h01, 8'(powerup_pending_out));
      for (n = 0; powerup_pending_out === 1'b1 && n < 3000; n++) @(negedge core_clk_in);
      chk("wake_time", 8'h01, 8'(n == WAKE_CYCLES - 1));
      chk("pair_a", 8'(codes[i] != PD_CODE_PAIR_B), 8'(pair_a_ready_out));
      chk("pair_b", 8'(codes[i] != PD_CODE_PAIR_A), 8'(pair_b_ready_out));
    end
    // Abort a wake part way: nothing may come up afterwards
    wr(REG_DAC_POWER_DOWN_CTRL, PD_CODE_ALL);
    wr(REG_DAC_POWER_DOWN_CTRL, PD_CODE_NONE);
    repeat (100) @(negedge core_clk_in);
    wr(REG_DAC_POWER_DOWN_CTRL, PD_CODE_ALL);
    @(negedge core_clk_in) chk("cancel_pending", 8'h00, 8'(powerup_pending_out));
    repeat (WAKE_CYCLES) @(negedge core_clk_in);
    chk("cancel_pairs", 8'h00, 8'({pair_a_ready_out, pair_b_ready_out}));
    for (int b = 1; b >= 0; b--) begin
      wr(REG_SYNC_OUTPUT_SWING_CTRL, 8'(b));
      repeat (2) @(negedge core_clk_in);
      chk("swing", 8'(b), 8'(sync_high_swing_out));
    end
    wr(10'h3FF, 8'h01);
    rd(REG_SYNC_OUTPUT_SWING_CTRL, SWING_RESET_VAL);
    while (ui_seen % 20 != 10) @(negedge core_clk_in);
    chk("pclk_toggles", 8'(ui_seen / 20), 8'(tog_seen));
    summarize();
  end
  // Watchdog: about 1.6 times the expected run
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule // dac_path_powerup_sync_cfg_tb_top
bind dac_path_powerup_sync_cfg dac_pwr_monitor mon (.*);
`default_nettype wire
